// file: core/tcic_top.sv
// How it works
// - prescaler passes every 1, 2, 4, 8 events
// - enable low clears the prescaler event count
// - channel 2 select: output, own, channel 3, trigger
// - channel 3 select: output, own, channel 2, trigger
// - select field writable only while enable low
// - filter code zero samples every system clock
// - filter is an N-event counter at sampling rate
// - codes 1 to 3: input clock, N 2/4/8
// - codes 4 to 9: base /2,/4,/8, N 6/8
// - codes 10 to 15: base /16,/32, N 5/6/8
// - each filter conditions its own channel pin
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module tcic_top
    import tcic_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // channel control enables
    input  wire logic        chan2_enable,
    input  wire logic        chan3_enable,
    // sampling ticks and trigger
    input  wire logic        timer_input_clock,
    input  wire logic        dead_time_base_clock,
    input  wire logic        trigger_edge_signal,
    // timer input pins
    input  wire logic        timer_pin_two,
    input  wire logic        timer_pin_three,
    // conditioned results
    output logic             chan2_pin_filter,
    output logic             chan3_pin_filter,
    output logic             chan2_capture_event,
    output logic             chan3_capture_event
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [3:0] flt_events(input logic [3:0] code);
        case (code)
            4'h0:                 flt_events = 4'h1;
            4'h1:                 flt_events = 4'h2;
            4'h2:                 flt_events = 4'h4;
            4'h4, 4'h6, 4'h8:     flt_events = 4'h6;
            4'hA, 4'hD:           flt_events = 4'h5;
            4'hB, 4'hE:           flt_events = 4'h6;
            default:              flt_events = 4'h8;
        endcase
    endfunction

    function automatic logic flt_tick(input logic [3:0] code, input logic in_tick,
                                      input logic [4:0] div_tick);
        case (code)
            4'h0:                 flt_tick = 1'b1;
            4'h1, 4'h2, 4'h3:     flt_tick = in_tick;
            4'h4, 4'h5:           flt_tick = div_tick[0];
            4'h6, 4'h7:           flt_tick = div_tick[1];
            4'h8, 4'h9:           flt_tick = div_tick[2];
            4'hA, 4'hB, 4'hC:     flt_tick = div_tick[3];
            default:              flt_tick = div_tick[4];
        endcase
    endfunction

    function automatic logic [2:0] psc_limit(input logic [1:0] psc);
        case (psc)
            2'h0:    psc_limit = 3'h0;
            2'h1:    psc_limit = 3'h1;
            2'h2:    psc_limit = 3'h3;
            default: psc_limit = 3'h7;
        endcase
    endfunction

    function automatic logic [31:0] cfg_word(input tcic_cfg_t c);
        logic [31:0] w;
        w = 32'h00000000;
        w[PSC_LSB +: 2] = c.psc;
        w[SEL_LSB +: 2] = c.sel;
        w[FLT_LSB +: 4] = c.flt;
        cfg_word = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    tcic_cfg_t   cfg_ff     [2];
    logic [1:0]  pin_s1_ff;
    logic [1:0]  pin_s2_ff;
    logic [4:0]  dcnt_ff;
    logic [4:0]  div_tick;
    logic [1:0]  smp_tick;
    logic [1:0]  filt_ff;
    logic [3:0]  fcnt_ff    [2];
    logic [1:0]  src;
    logic [1:0]  src_prev_ff;
    logic [2:0]  pcnt_ff    [2];
    logic [1:0]  evt_ff;
    logic [1:0]  en;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        wr_ch2;
    logic        wr_ch3;

    assign en     = {chan3_enable, chan2_enable};
    assign wr_ch2 = reg_wr && (reg_addr == CHAN2_INPUT_CONFIG_OFS);
    assign wr_ch3 = reg_wr && (reg_addr == CHAN3_INPUT_CONFIG_OFS);

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff[0] <= CFG_RESET;
            cfg_ff[1] <= CFG_RESET;
        end else begin
            if (wr_ch2) begin
                cfg_ff[0].psc <= reg_wdata[PSC_LSB +: 2];
                cfg_ff[0].flt <= reg_wdata[FLT_LSB +: 4];
                if (!chan2_enable) begin
                    cfg_ff[0].sel <= tcic_sel_t'(reg_wdata[SEL_LSB +: 2]);
                end
            end
            if (wr_ch3) begin
                cfg_ff[1].psc <= reg_wdata[PSC_LSB +: 2];
                cfg_ff[1].flt <= reg_wdata[FLT_LSB +: 4];
                if (!chan3_enable) begin
                    cfg_ff[1].sel <= tcic_sel_t'(reg_wdata[SEL_LSB +: 2]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port

    always_comb begin
        nxt_rdata = 32'h00000000;
        case (reg_addr)
            CHAN2_INPUT_CONFIG_OFS: nxt_rdata = cfg_word(cfg_ff[0]);
            CHAN3_INPUT_CONFIG_OFS: nxt_rdata = cfg_word(cfg_ff[1]);
            INPUT_STATUS_OFS: begin
                nxt_rdata[STAT_LEVEL2_BIT]     = filt_ff[0];
                nxt_rdata[STAT_LEVEL3_BIT]     = filt_ff[1];
                nxt_rdata[STAT_PCNT2_LSB +: 3] = pcnt_ff[0];
                nxt_rdata[STAT_PCNT3_LSB +: 3] = pcnt_ff[1];
            end
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_ff <= 2'h0;
            pin_s2_ff <= 2'h0;
        end else begin
            pin_s1_ff <= {timer_pin_three, timer_pin_two};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sampling rate divider of the base clock

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dcnt_ff <= 5'h00;
        end else if (dead_time_base_clock) begin
            dcnt_ff <= dcnt_ff + 5'h01;
        end
    end

    always_comb begin
        div_tick[0] = dead_time_base_clock && dcnt_ff[0];
        div_tick[1] = dead_time_base_clock && (&dcnt_ff[1:0]);
        div_tick[2] = dead_time_base_clock && (&dcnt_ff[2:0]);
        div_tick[3] = dead_time_base_clock && (&dcnt_ff[3:0]);
        div_tick[4] = dead_time_base_clock && (&dcnt_ff[4:0]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // digital noise filters

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            smp_tick[i] = flt_tick(cfg_ff[i].flt, timer_input_clock, div_tick);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_ff    <= 2'h0;
            fcnt_ff[0] <= 4'h0;
            fcnt_ff[1] <= 4'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (smp_tick[i]) begin
                    if (pin_s2_ff[i] == filt_ff[i]) begin
                        fcnt_ff[i] <= 4'h0;
                    end else if (fcnt_ff[i] + 4'h1 >= flt_events(cfg_ff[i].flt)) begin
                        filt_ff[i] <= pin_s2_ff[i];
                        fcnt_ff[i] <= 4'h0;
                    end else begin
                        fcnt_ff[i] <= fcnt_ff[i] + 4'h1;
                    end
                end
            end
        end
    end

    assign chan2_pin_filter = filt_ff[0];
    assign chan3_pin_filter = filt_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    // capture source selection

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            case (cfg_ff[i].sel)
                SEL_OWN_PIN:  src[i] = filt_ff[i];
                SEL_PAIR_PIN: src[i] = filt_ff[1 - i];
                SEL_TRIGGER:  src[i] = trigger_edge_signal;
                default:      src[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_prev_ff <= 2'h0;
        end else begin
            src_prev_ff <= src;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capture prescalers

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pcnt_ff[0] <= 3'h0;
            pcnt_ff[1] <= 3'h0;
            evt_ff     <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                evt_ff[i] <= 1'b0;
                if (!en[i]) begin
                    pcnt_ff[i] <= 3'h0;
                end else if (src[i] && !src_prev_ff[i]) begin
                    if (pcnt_ff[i] >= psc_limit(cfg_ff[i].psc)) begin
                        pcnt_ff[i] <= 3'h0;
                        evt_ff[i]  <= 1'b1;
                    end else begin
                        pcnt_ff[i] <= pcnt_ff[i] + 3'h1;
                    end
                end
            end
        end
    end

    assign chan2_capture_event = evt_ff[0];
    assign chan3_capture_event = evt_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_sel_locked;
        @(posedge clk) disable iff (!rst_b)
        (wr_ch2 && chan2_enable) |=> (cfg_ff[0].sel == $past(cfg_ff[0].sel));
    endproperty
    a_sel_locked: assert property (p_sel_locked) else $error("select changed while enabled");

    property p_sel_open;
        @(posedge clk) disable iff (!rst_b)
        (wr_ch3 && !chan3_enable) |=> (cfg_ff[1].sel == $past(reg_wdata[SEL_LSB +: 2]));
    endproperty
    a_sel_open: assert property (p_sel_open) else $error("select write lost");

    property p_psc_clear;
        @(posedge clk) disable iff (!rst_b)
        !chan2_enable |=> (pcnt_ff[0] == 3'h0) && !evt_ff[0];
    endproperty
    a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared");

    property p_psc_eight;
        @(posedge clk) disable iff (!rst_b)
        (evt_ff[0] && cfg_ff[0].psc == 2'h3) |-> $past(pcnt_ff[0]) == 3'h7;
    endproperty
    a_psc_eight: assert property (p_psc_eight) else $error("event before eighth edge");

    property p_psc_each;
        @(posedge clk) disable iff (!rst_b)
        (chan2_enable && cfg_ff[0].psc == 2'h0 && src[0] && !src_prev_ff[0]) |=> evt_ff[0];
    endproperty
    a_psc_each: assert property (p_psc_each) else $error("event missed without prescale");

    property p_pair_src;
        @(posedge clk) disable iff (!rst_b)
        (cfg_ff[0].sel == SEL_PAIR_PIN) |-> (src[0] == filt_ff[1]);
    endproperty
    a_pair_src: assert property (p_pair_src) else $error("channel 2 pair source wrong");

    property p_trig_src;
        @(posedge clk) disable iff (!rst_b)
        (cfg_ff[1].sel == SEL_TRIGGER) |-> (src[1] == trigger_edge_signal);
    endproperty
    a_trig_src: assert property (p_trig_src) else $error("channel 3 trigger source wrong");

    property p_no_filter;
        @(posedge clk) disable iff (!rst_b)
        (cfg_ff[0].flt == 4'h0 && pin_s2_ff[0] != filt_ff[0]) |=> filt_ff[0] == $past(pin_s2_ff[0]);
    endproperty
    a_no_filter: assert property (p_no_filter) else $error("unfiltered input not followed");

    property p_restart;
        @(posedge clk) disable iff (!rst_b)
        (smp_tick[1] && pin_s2_ff[1] == filt_ff[1]) |=> fcnt_ff[1] == 4'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("filter count not restarted");

    property p_n_events;
        @(posedge clk) disable iff (!rst_b)
        (cfg_ff[0].flt == 4'h3 && $changed(filt_ff[0]) && $stable(cfg_ff[0].flt))
            |-> $past(fcnt_ff[0]) == 4'h7;
    endproperty
    a_n_events: assert property (p_n_events) else $error("filter changed before eight");

    property p_rate_in;
        @(posedge clk) disable iff (!rst_b)
        (cfg_ff[0].flt == 4'h2) |-> (smp_tick[0] == timer_input_clock);
    endproperty
    a_rate_in: assert property (p_rate_in) else $error("wrong sample rate");

    property p_rate_div;
        @(posedge clk) disable iff (!rst_b)
        (cfg_ff[0].flt == 4'h7 && smp_tick[0]) |-> dead_time_base_clock && dcnt_ff[1:0] == 2'h3;
    endproperty
    a_rate_div: assert property (p_rate_div) else $error("wrong divide by four");

    property p_rate_32;
        @(posedge clk) disable iff (!rst_b)
        (cfg_ff[0].flt == 4'hD && smp_tick[0]) |-> dcnt_ff == 5'h1F;
    endproperty
    a_rate_32: assert property (p_rate_32) else $error("wrong divide by thirty-two");

endmodule

`default_nettype wire

// file: core/tcic_pkg.sv
`default_nettype none

package tcic_pkg;

    // register map
    localparam logic [7:0]  CHAN2_INPUT_CONFIG_OFS = 8'h28;
    localparam logic [7:0]  CHAN3_INPUT_CONFIG_OFS = 8'h2C;
    localparam logic [7:0]  INPUT_STATUS_OFS       = 8'h30;
    localparam logic [31:0] CONFIG_RESET           = 32'h00000000;

    // config field positions
    localparam int PSC_LSB = 18;
    localparam int SEL_LSB = 16;
    localparam int FLT_LSB = 0;

    // status field positions
    localparam int STAT_LEVEL2_BIT = 0;
    localparam int STAT_LEVEL3_BIT = 1;
    localparam int STAT_PCNT2_LSB  = 4;
    localparam int STAT_PCNT3_LSB  = 8;

    // channel direction select codes
    typedef enum logic [1:0] {
        SEL_COMPARE_OUT = 2'h0,
        SEL_OWN_PIN     = 2'h1,
        SEL_PAIR_PIN    = 2'h2,
        SEL_TRIGGER     = 2'h3
    } tcic_sel_t;

    // one channel's configuration
    typedef struct packed {
        logic [1:0] psc;
        tcic_sel_t  sel;
        logic [3:0] flt;
    } tcic_cfg_t;

    localparam tcic_cfg_t CFG_RESET = '{psc: 2'h0, sel: SEL_COMPARE_OUT, flt: 4'h0};

endpackage

`default_nettype wire

// file: bench/tcic_pins.sv
`timescale 1ns/1ps
`default_nettype none

module tcic_pins (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // commanded levels
    input  wire logic pin2_cmd,
    input  wire logic pin3_cmd,
    input  wire logic trig_cmd,
    // pins, trigger and ticks
    output logic      timer_pin_two,
    output logic      timer_pin_three,
    output logic      trigger_edge_signal,
    output logic      timer_input_clock,
    output logic      dead_time_base_clock
);

////////////////////////////////////////////////////////////////////////////////
// pins follow commands one edge late
always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        timer_pin_two       <= 1'b0;
        timer_pin_three     <= 1'b0;
        trigger_edge_signal <= 1'b0;
    end else begin
        timer_pin_two       <= pin2_cmd;
        timer_pin_three     <= pin3_cmd;
        trigger_edge_signal <= trig_cmd;
    end
end

////////////////////////////////////////////////////////////////////////////////
// input clock tick every other cycle, base tick every cycle
always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        timer_input_clock    <= 1'b0;
        dead_time_base_clock <= 1'b0;
    end else begin
        timer_input_clock    <= ~timer_input_clock;
        dead_time_base_clock <= 1'b1;
    end
end

endmodule

`default_nettype wire

// file: bench/tcic_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module tcic_top_test;
    import tcic_pkg::*;

logic        clk, rst_b, reg_wr, reg_rd, chan2_enable, chan3_enable;
logic [7:0]  reg_addr;
logic [31:0] reg_wdata, rd_val;
logic        pin2_cmd, pin3_cmd, trig_cmd;
wire  logic  [31:0] reg_rdata;
wire  logic  pin2, pin3, trig, tick_in, tick_dts, f2, f3, ev2_o, ev3_o;
int          mismatches, tests_run, cyc, ev2, ev3, n2, n3;
int          nt[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
int          dv[16] = '{1, 2, 2, 2, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};

tcic_pins u_pins (.clk(clk), .rst_b(rst_b), .pin2_cmd(pin2_cmd), .pin3_cmd(pin3_cmd),
    .trig_cmd(trig_cmd), .timer_pin_two(pin2), .timer_pin_three(pin3),
    .trigger_edge_signal(trig), .timer_input_clock(tick_in),
    .dead_time_base_clock(tick_dts));

tcic_top DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan2_enable(chan2_enable), .chan3_enable(chan3_enable),
    .timer_input_clock(tick_in), .dead_time_base_clock(tick_dts),
    .trigger_edge_signal(trig), .timer_pin_two(pin2), .timer_pin_three(pin3),
    .chan2_pin_filter(f2), .chan3_pin_filter(f3),
    .chan2_capture_event(ev2_o), .chan3_capture_event(ev3_o));

////////////////////////////////////////////////////////////////////////////////
// clock, event counters, timeout
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end

always @(posedge clk) begin
    ev2 += (ev2_o === 1'b1);
    ev3 += (ev3_o === 1'b1);
    cyc++;
    if (cyc == 40000) begin
        mismatches++;
        final_report;
    end
end

////////////////////////////////////////////////////////////////////////////////
// tasks
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
        mismatches++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
endtask

task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
endtask

task automatic cfg(input int ch, input logic [31:0] v);
    @(posedge clk);
    if (ch == 2) chan2_enable <= 1'b0;
    else chan3_enable <= 1'b0;
    wr(ch == 2 ? CHAN2_INPUT_CONFIG_OFS : CHAN3_INPUT_CONFIG_OFS, v);
    @(posedge clk);
    if (ch == 2) chan2_enable <= 1'b1;
    else chan3_enable <= 1'b1;
endtask

task automatic pulse(input int w);
    @(posedge clk);
    if (w == 0) pin2_cmd <= 1'b1;
    else if (w == 1) pin3_cmd <= 1'b1;
    else trig_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    {pin2_cmd, pin3_cmd, trig_cmd} <= 3'h0;
    repeat (6) @(posedge clk);
endtask

task automatic meas(input logic lvl);
    @(posedge clk);
    pin2_cmd <= lvl;
    pin3_cmd <= lvl;
    n2 = 0;
    n3 = 0;
    repeat (600) begin
        @(posedge clk);
        #1;
        n2 += (f2 !== lvl);
        n3 += (f3 !== lvl);
    end
endtask

task automatic final_report;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask

////////////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    {rst_b, reg_wr, reg_rd, chan2_enable, chan3_enable} = 5'h0;
    {pin2_cmd, pin3_cmd, trig_cmd} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, unmapped place, reserved bits
    rd(CHAN2_INPUT_CONFIG_OFS, rd_val); check(rd_val, CONFIG_RESET);
    rd(CHAN3_INPUT_CONFIG_OFS, rd_val); check(rd_val, CONFIG_RESET);
    rd(8'h34, rd_val); check(rd_val, 32'h00000000);
    wr(CHAN2_INPUT_CONFIG_OFS, 32'hFFFFFFFF);
    rd(CHAN2_INPUT_CONFIG_OFS, rd_val); check(rd_val, 32'h000F000F);
    // select locked while enabled
    cfg(2, 32'h00030000);
    wr(CHAN2_INPUT_CONFIG_OFS, 32'h000D0005);
    rd(CHAN2_INPUT_CONFIG_OFS, rd_val); check(rd_val, 32'h000F0005);
    @(posedge clk) chan2_enable <= 1'b0;
    wr(CHAN2_INPUT_CONFIG_OFS, 32'h000D0005);
    rd(CHAN2_INPUT_CONFIG_OFS, rd_val); check(rd_val, 32'h000D0005);
    // source selection, every code on both channels
    for (int s = 0; s < 4; s++) begin
        cfg(2, 32'(s) << SEL_LSB);
        cfg(3, 32'(s) << SEL_LSB);
        for (int w = 0; w < 3; w++) begin
            ev2 = 0;
            ev3 = 0;
            pulse(w);
            check(ev2, (w == 0 && s == 1) || (w == 1 && s == 2) || (w == 2 && s == 3));
            check(ev3, (w == 1 && s == 1) || (w == 0 && s == 2) || (w == 2 && s == 3));
        end
    end
    // prescaler ratios
    for (int p = 0; p < 4; p++) begin
        cfg(2, 32'h00010000 | (32'(p) << PSC_LSB));
        ev2 = 0;
        repeat (8) pulse(0);
        check(ev2, 8 >> p);
    end
    // disable mid-count restarts the prescaler
    cfg(2, 32'h00050000);
    ev2 = 0;
    pulse(0);
    rd(INPUT_STATUS_OFS, rd_val); check(rd_val, 32'h00000001 << STAT_PCNT2_LSB);
    @(posedge clk) chan2_enable <= 1'b0;
    repeat (2) @(posedge clk);
    chan2_enable <= 1'b1;
    pulse(0);
    check(ev2, 0);
    pulse(0);
    check(ev2, 1);
    // filter delays per code, channel 3 unfiltered
    cfg(3, 32'h00010000);
    for (int c = 0; c < 16; c++) begin
        cfg(2, 32'h00010000 | 32'(c));
        for (int l = 1; l >= 0; l--) begin
            meas(l[0]);
            check(n3, 3);
            if (c == 0) check(n2, 3);
            else check(n2 >= 2 + (nt[c] - 1) * dv[c] && n2 <= 5 + nt[c] * dv[c], 1);
            rd(INPUT_STATUS_OFS, rd_val);
            check(rd_val, (32'(l) << STAT_LEVEL2_BIT) | (32'(l) << STAT_LEVEL3_BIT));
        end
    end
    // two glitches split by a short gap never add up in an eight-sample filter
    cfg(2, 32'h00010003);
    n2 = 0;
    @(posedge clk) pin2_cmd <= 1'b1;
    repeat (9) @(posedge clk);
    pin2_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    pin2_cmd <= 1'b1;
    repeat (9) @(posedge clk);
    pin2_cmd <= 1'b0;
    repeat (20) begin
        @(posedge clk);
        #1 n2 += (f2 !== 1'b0);
    end
    check(n2, 0);
    final_report;
end

endmodule

`default_nettype wire
